// ### rtl/uevt_pkg.sv
// package for the uart event and flow timing block: constants and types
// assumes one 200 MHz system clock; baud ticks are derived inside the block
// ****************************************************************
// ****************************************************************
`default_nettype none
package uevt_pkg;
  localparam int unsigned UEVT_OVERSAMPLE = 16;
  localparam int unsigned UEVT_MID_SAMPLE = 7;
  localparam int unsigned UEVT_DATA_BITS = 8;
  localparam int unsigned UEVT_QUEUE_DEPTH = 16;
  localparam logic [15:0] UEVT_DIVISOR_RESET = 16'h0001;
  localparam logic [1:0] UEVT_TRIG_RESET = 2'h0;
  // transmit start latency in baud ticks after an idle write
  localparam int unsigned UEVT_TX_START_TICKS = 16;
  // holding empty raised this many ticks after the start bit
  localparam int unsigned UEVT_EMPTY_AFTER_START = 8;
  // transmit ready returns this many ticks after the start bit
  localparam int unsigned UEVT_READY_AFTER_START = 9;
  typedef enum logic [1:0] {
    UEVT_TX_IDLE = 2'b00,
    UEVT_TX_WAIT = 2'b01,
    UEVT_TX_SHIFT = 2'b10
  } uevt_tx_state_t;
  typedef enum logic [1:0] {
    UEVT_RX_IDLE = 2'b00,
    UEVT_RX_START = 2'b01,
    UEVT_RX_DATA = 2'b10,
    UEVT_RX_STOP = 2'b11
  } uevt_rx_state_t;
  // receive threshold code to byte count, codes 0..3 -> 1,4,8,14
  function automatic logic [4:0] uevt_trig_level(input logic [1:0] code);
    unique case (code)
      2'h0: uevt_trig_level = 5'h01;
      2'h1: uevt_trig_level = 5'h04;
      2'h2: uevt_trig_level = 5'h08;
      2'h3: uevt_trig_level = 5'h0e;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### rtl/uevt_queue.sv
// receive byte queue with registered read data
// assumes the writer never pushes when full
`timescale 1ns/100ps
`default_nettype none
module uevt_queue #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // write side
  input wire logic i_push,
  input wire logic [WIDTH-1:0] i_data,
  // read side
  input wire logic i_pop,
  output logic [WIDTH-1:0] o_data,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be power of 2");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic do_pop;
  assign do_pop = i_pop && (cnt_reg != '0);
  assign o_count = cnt_reg;
  // storage has no reset; pointers guard it
  always_ff @(posedge i_clk) begin
    if (i_push) begin
      mem_reg[wr_reg] <= i_data;
    end
  end
  // pointers and fill level
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (i_push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, i_push} - {{AW{1'b0}}, do_pop};
    end
  end
  // head word always presented from a register
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_data <= '0;
    end else if (i_push && (cnt_reg == '0 || (do_pop && cnt_reg == 1))) begin
      o_data <= i_data;
    end else if (do_pop) begin
      o_data <= mem_reg[rd_reg + 1'b1];
    end
  end
endmodule
`default_nettype wire

// ### rtl/uevt_core.sv
// uart event timing core: receiver, transmitter, flow control, irq flags
// assumes host strobes are one-cycle pulses synchronous to i_clk
`timescale 1ns/100ps
`default_nettype none
module uevt_core
  import uevt_pkg::*;
#(
  parameter int unsigned DEPTH = UEVT_QUEUE_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // configuration
  input wire logic [15:0] i_divisor,
  input wire logic i_auto_rts,
  input wire logic i_auto_cts,
  input wire logic [1:0] i_rx_trigger,
  // receive clock enable, one cycle per rclk edge
  input wire logic i_rclk_tick,
  // host strobes
  input wire logic i_write_holding,
  input wire logic [7:0] i_write_data,
  input wire logic i_rx_buffer_read_strobe,
  input wire logic i_read_line_status,
  input wire logic i_read_irq_ident,
  // serial line
  input wire logic i_rx,
  input wire logic i_cts_n,
  output logic o_tx,
  output logic o_rts_n,
  // status
  output logic [7:0] o_receive_buffer,
  output logic [4:0] o_rx_count,
  output logic o_rx_irq,
  output logic o_line_status_irq,
  output logic o_tx_holding_empty,
  output logic o_rx_ready_n,
  output logic o_tx_ready_n,
  output logic o_baud_tick
);
  initial begin
    if (DEPTH != 16) $error("queue depth must be 16");
  end
  // ****************************************************************
  // baud generator
  // ****************************************************************
  logic [15:0] div_reg;
  logic baud_tick;
  assign baud_tick = (div_reg <= 16'h0001);
  assign o_baud_tick = baud_tick;
  // one tick per divisor reference cycles; zero treated as one
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      div_reg <= UEVT_DIVISOR_RESET;
    end else if (baud_tick) begin
      div_reg <= i_divisor;
    end else begin
      div_reg <= div_reg - 16'h0001;
    end
  end
  // ****************************************************************
  // receiver
  // ****************************************************************
  uevt_rx_state_t rx_state_reg;
  logic [3:0] rx_os_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic rx_push;
  logic [4:0] q_count;
  logic [7:0] q_data;
  // mid-bit sampling on the receive clock enable only
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rx_state_reg <= UEVT_RX_IDLE;
      rx_os_reg <= '0;
      rx_bit_reg <= '0;
      rx_shift_reg <= '0;
      rx_push <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (i_rclk_tick) begin
        rx_os_reg <= rx_os_reg + 4'h1;
        unique case (rx_state_reg)
          UEVT_RX_IDLE: begin
            rx_os_reg <= '0;
            if (!i_rx) begin
              rx_state_reg <= UEVT_RX_START;
            end
          end
          UEVT_RX_START: begin
            if (rx_os_reg == 4'(UEVT_MID_SAMPLE)) begin
              rx_os_reg <= '0;
              rx_bit_reg <= '0;
              rx_state_reg <= i_rx ? UEVT_RX_IDLE : UEVT_RX_DATA;
            end
          end
          UEVT_RX_DATA: begin
            if (rx_os_reg == 4'hf) begin
              rx_shift_reg <= {i_rx, rx_shift_reg[7:1]};
              rx_bit_reg <= rx_bit_reg + 3'h1;
              if (rx_bit_reg == 3'h7) begin
                rx_state_reg <= UEVT_RX_STOP;
              end
            end
          end
          UEVT_RX_STOP: begin
            if (rx_os_reg == 4'hf) begin
              rx_state_reg <= UEVT_RX_IDLE;
              // a full queue drops the character; the status irq flags it
              if (q_count != 5'(DEPTH)) begin
                rx_push <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end
  uevt_queue #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) u_queue (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_push(rx_push),
    .i_data(rx_shift_reg),
    .i_pop(i_rx_buffer_read_strobe),
    .o_data(q_data),
    .o_count(q_count)
  );
  assign o_receive_buffer = q_data;
  assign o_rx_count = q_count;
  // receive irq follows queue level; reading drains it
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rx_irq <= 1'b0;
      o_rx_ready_n <= 1'b1;
      o_line_status_irq <= 1'b0;
    end else begin
      o_rx_irq <= rx_push || (q_count > (i_rx_buffer_read_strobe ? 5'h01
                                                             : 5'h00));
      o_rx_ready_n <= !(rx_push || (q_count > (i_rx_buffer_read_strobe ?
                                              5'h01 : 5'h00)));
      // a new overrun wins over a status read in the same cycle
      o_line_status_irq <= (rx_push == 1'b0 && rx_state_reg == UEVT_RX_STOP
                            && i_rclk_tick && rx_os_reg == 4'hf
                            && q_count == 5'(DEPTH))
                           || (o_line_status_irq && !i_read_line_status);
    end
  end
  // ****************************************************************
  // auto request-to-send
  // ****************************************************************
  logic rts_drop;
  logic rts_raise;
  assign rts_drop = (i_rx_trigger == 2'h3)
    ? (rx_state_reg == UEVT_RX_DATA && rx_bit_reg == 3'h0
       && q_count == 5'h0f)
    : (q_count >= uevt_trig_level(i_rx_trigger));
  assign rts_raise = (i_rx_trigger == 2'h3)
    ? i_rx_buffer_read_strobe
    : (q_count == 5'h00);
  // reacts in one clock, well inside two baud ticks
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rts_n <= 1'b1;
    end else if (!i_auto_rts) begin
      o_rts_n <= 1'b0;
    end else if (rts_drop) begin
      o_rts_n <= 1'b1;
    end else if (rts_raise) begin
      o_rts_n <= 1'b0;
    end
  end
  // ****************************************************************
  // transmitter
  // ****************************************************************
  uevt_tx_state_t tx_state_reg;
  logic [7:0] hold_reg;
  logic hold_full_reg;
  logic [7:0] tx_shift_reg;
  logic [3:0] tx_os_reg;
  logic [3:0] tx_bit_reg;
  logic [4:0] tx_wait_reg;
  logic [3:0] empty_cnt_reg;
  logic empty_arm_reg;
  logic empty_set;
  logic cts_ok;
  assign cts_ok = !i_auto_cts || !i_cts_n;
  // frame: start, 8 data, stop; each bit 16 baud ticks
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      tx_state_reg <= UEVT_TX_IDLE;
      tx_shift_reg <= '0;
      tx_os_reg <= '0;
      tx_bit_reg <= '0;
      tx_wait_reg <= '0;
      o_tx <= 1'b1;
    end else if (baud_tick) begin
      unique case (tx_state_reg)
        UEVT_TX_IDLE: begin
          tx_wait_reg <= '0;
          if (hold_full_reg && cts_ok) begin
            tx_state_reg <= UEVT_TX_WAIT;
          end
        end
        UEVT_TX_WAIT: begin
          tx_wait_reg <= tx_wait_reg + 5'h01;
          if (tx_wait_reg == 5'(UEVT_TX_START_TICKS - 2)) begin
            tx_state_reg <= UEVT_TX_SHIFT;
            tx_shift_reg <= hold_reg;
            tx_os_reg <= '0;
            tx_bit_reg <= '0;
            o_tx <= 1'b0;
          end
        end
        UEVT_TX_SHIFT: begin
          tx_os_reg <= tx_os_reg + 4'h1;
          if (tx_os_reg == 4'hf) begin
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg <= 4'h7) begin
              o_tx <= tx_shift_reg[tx_bit_reg[2:0]];
            end else if (tx_bit_reg == 4'h8) begin
              o_tx <= 1'b1;
            end else begin
              tx_state_reg <= UEVT_TX_IDLE;
            end
          end
          // stop-bit midpoint decides whether the next may follow
          if (tx_bit_reg == 4'h9 && tx_os_reg == 4'h7 && hold_full_reg
              && cts_ok) begin
            tx_state_reg <= UEVT_TX_WAIT;
            tx_wait_reg <= '0;
          end
        end
        default: tx_state_reg <= UEVT_TX_IDLE;
      endcase
    end
  end
  // holding register empties when the shifter loads it
  logic tx_load;
  assign tx_load = baud_tick && tx_state_reg == UEVT_TX_WAIT
                   && tx_wait_reg == 5'(UEVT_TX_START_TICKS - 2);
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      hold_reg <= '0;
      hold_full_reg <= 1'b0;
    end else if (i_write_holding) begin
      hold_reg <= i_write_data;
      hold_full_reg <= 1'b1;
    end else if (tx_load) begin
      hold_full_reg <= 1'b0;
    end
  end
  // holding empty irq: counted from start bit, cleared by write or ident read;
  // the set wins over a clear that lands in the same cycle
  assign empty_set = empty_arm_reg && baud_tick && !hold_full_reg
                     && empty_cnt_reg == 4'(UEVT_EMPTY_AFTER_START - 1);
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      empty_cnt_reg <= '0;
      empty_arm_reg <= 1'b0;
      o_tx_holding_empty <= 1'b0;
      o_tx_ready_n <= 1'b0;
    end else begin
      if (tx_load) begin
        empty_arm_reg <= 1'b1;
        empty_cnt_reg <= '0;
      end else if (empty_arm_reg && baud_tick) begin
        empty_cnt_reg <= empty_cnt_reg + 4'h1;
        if (empty_cnt_reg == 4'(UEVT_READY_AFTER_START - 1)) begin
          empty_arm_reg <= 1'b0;
        end
      end
      if (empty_set) begin
        o_tx_holding_empty <= 1'b1;
      end else if (i_write_holding || i_read_irq_ident) begin
        o_tx_holding_empty <= 1'b0;
      end
      if (i_write_holding) begin
        o_tx_ready_n <= 1'b1;
      end else if (empty_arm_reg && baud_tick && !hold_full_reg
                   && empty_cnt_reg == 4'(UEVT_READY_AFTER_START - 1)) begin
        o_tx_ready_n <= 1'b0;
      end
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  rts_drop_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_auto_rts && rts_drop |=> o_rts_n) else $error("rts not dropped");
  rts_raise_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_auto_rts && !rts_drop && rts_raise |=> !o_rts_n)
    else $error("rts not raised");
  rx_irq_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    rx_push |=> o_rx_irq && !o_rx_ready_n) else $error("rx irq late");
  hold_clr_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_write_holding && !empty_set |=> !o_tx_holding_empty)
    else $error("holding empty not cleared");
  rdy_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_write_holding |=> o_tx_ready_n) else $error("tx ready not inactive");
  start_bit_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    tx_load |=> !o_tx) else $error("start bit missing");
  id_clr_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_read_irq_ident && !empty_set |=> !o_tx_holding_empty)
    else $error("ident read kept holding empty");
  tx_idle_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    tx_state_reg == UEVT_TX_IDLE && $past(tx_state_reg) == UEVT_TX_IDLE
    |-> o_tx) else $error("idle line low");
  rx_seen_c: cover property (@(posedge i_clk) rx_push);
  empty_seen_c: cover property (@(posedge i_clk) $rose(o_tx_holding_empty));
  rts_seen_c: cover property (@(posedge i_clk) $rose(o_rts_n));
endmodule
`default_nettype wire

// ### bench/uevt_remote.sv
// remote serial device model: sends 8N1 characters, decodes the tx line
// assumes rclk and baud ticks are one-cycle enables, 16 per bit
`timescale 1ns/100ps
`default_nettype none
module uevt_remote (
  // clock and tick enables
  input wire logic i_clk,
  input wire logic i_rclk_tick,
  input wire logic i_baud_tick,
  // serial lines
  input wire logic i_tx,
  output logic o_rx,
  // decoded characters
  output logic [7:0] o_last,
  output logic [7:0] o_count
);
  // ****************************************************************
  // line driver and decoder
  // ****************************************************************
  logic [7:0] sh;

  // idle line is high, nothing decoded yet
  initial begin
    o_rx = 1'b1;
    o_last = 8'h00;
    o_count = 8'h00;
  end

  // wait n enables; sampled on the falling edge to stay clear of races
  task automatic wait_ticks(input logic rclk, input int n);
    repeat (n) begin
      do @(negedge i_clk); while ((rclk ? i_rclk_tick : i_baud_tick) !== 1'b1);
      @(posedge i_clk);
    end
  endtask

  // one character, lsb first, bits timed on the receive clock
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rx <= f[i];
      wait_ticks(1'b1, 16);
    end
  endtask

  // decoder samples mid-bit so a tick of phase slip is harmless
  always begin
    @(negedge i_clk);
    if (i_tx === 1'b0) begin
      wait_ticks(1'b0, 8);
      for (int i = 0; i < 8; i++) begin
        wait_ticks(1'b0, 16);
        @(negedge i_clk);
        sh[i] = i_tx;
      end
      wait_ticks(1'b0, 16);
      o_last <= sh;
      o_count <= o_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### bench/uevt_core_bench.sv
// testbench for the uart event timing core: host strobes, serial traffic
// assumes the remote model is compiled first; one 200 MHz clock
`timescale 1ns/100ps
`default_nettype none
module uevt_core_bench
  import uevt_pkg::*;
;
  // ****************************************************************
  // stimulus, model and checks
  // ****************************************************************
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] divisor = 16'h0004;
  logic auto_rts = 1'b0;
  logic auto_cts = 1'b0;
  logic [1:0] trig = 2'h0;
  logic rclk_tick = 1'b0;
  logic [1:0] rdiv = 2'h0;
  logic [3:0] strb = 4'h0; // ident, status, buffer read, write
  logic [7:0] wdata = 8'h00;
  logic cts_n = 1'b0;
  logic rx_line, tx, rts_n, rx_irq, ls_irq, hold_empty, btick;
  logic rx_ready_n, tx_ready_n;
  logic [7:0] rbuf, got_byte, got_cnt, nb;
  logic [4:0] rx_count;
  logic [4:0] want = 5'h00;
  logic [8:0] obs;
  int mismatches = 0;
  int total_checks = 0;
  int ticks = 0;
  int t0, t1;
  int lvl [3] = '{1, 4, 8};

  assign obs = {rx_line, rx_count == want, rx_ready_n, ls_irq, rx_irq,
                tx_ready_n, hold_empty, rts_n, tx};

  // clock, and a receive clock at the 16x rate but its own phase
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    rdiv <= rdiv + 2'h1;
    rclk_tick <= (rdiv == 2'h1);
  end
  // running count of baud ticks used for all latency figures
  always @(posedge clk) if (btick === 1'b1) ticks <= ticks + 1;

  uevt_core #(.DEPTH(UEVT_QUEUE_DEPTH)) i_dut (
    .i_clk(clk), .i_reset_n(reset_n), .i_divisor(divisor),
    .i_auto_rts(auto_rts), .i_auto_cts(auto_cts), .i_rx_trigger(trig),
    .i_rclk_tick(rclk_tick), .i_write_holding(strb[0]),
    .i_write_data(wdata), .i_rx_buffer_read_strobe(strb[1]),
    .i_read_line_status(strb[2]), .i_read_irq_ident(strb[3]),
    .i_rx(rx_line), .i_cts_n(cts_n), .o_tx(tx), .o_rts_n(rts_n),
    .o_receive_buffer(rbuf), .o_rx_count(rx_count), .o_rx_irq(rx_irq),
    .o_line_status_irq(ls_irq), .o_tx_holding_empty(hold_empty),
    .o_rx_ready_n(rx_ready_n), .o_tx_ready_n(tx_ready_n), .o_baud_tick(btick)
  );

  uevt_remote i_remote (
    .i_clk(clk), .i_rclk_tick(rclk_tick), .i_baud_tick(btick),
    .i_tx(tx), .o_rx(rx_line), .o_last(got_byte), .o_count(got_cnt)
  );

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic span(input string what, input int lo, input int hi,
                      input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // bounded wait for one observed output, looked at 1 ns after the edge;
  // returns on the next rising edge so callers always drive on an edge
  task automatic wait_obs(input int idx, input logic v);
    int n;
    n = 0;
    while (obs[idx] !== v && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (obs[idx] !== v) check($sformatf("wait %0d", idx), 1, 0);
    @(posedge clk);
  endtask

  // one-cycle host strobe; write data must be set beforehand; returns on
  // the edge after the strobe, where its effect is already settled
  task automatic pulse(input int k);
    @(posedge clk);
    strb[k] <= 1'b1;
    @(posedge clk);
    strb <= 4'h0;
    @(posedge clk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs about 30k cycles
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t0 = ticks;
    repeat (40) @(posedge clk);
    check("baud ticks", 10, ticks - t0);
    // idle transmitter: start, holding empty and ready latencies
    wdata <= 8'h5a;
    pulse(0);
    t0 = ticks;
    check("tx ready off", 1, tx_ready_n);
    wait_obs(0, 1'b0);
    t1 = ticks;
    span("start", 8, 24, t1 - t0);
    wait_obs(2, 1'b1);
    span("empty from start", 8, 10, ticks - t1);
    span("empty from write", 16, 34, ticks - t0);
    wait_obs(3, 1'b0);
    check("tx ready back", 9, ticks - t1);
    wdata <= 8'hc3;
    pulse(0);
    check("empty by write", 0, hold_empty);
    wait_obs(2, 1'b1);
    pulse(3);
    check("empty by ident", 0, hold_empty);
    repeat (800) @(posedge clk);
    check("tx count", 2, got_cnt);
    check("tx byte", 8'hc3, got_byte);
    // single character received on the independent receive clock
    i_remote.send(8'h96);
    check("rx data", 8'h96, rbuf);
    check("rx ready", 0, rx_ready_n);
    check("rx irq", 1, rx_irq);
    pulse(1);
    repeat (2) @(posedge clk);
    check("rx irq clear", 0, rx_irq);
    check("rx ready clear", 1, rx_ready_n);
    // automatic request-to-send at thresholds 1, 4 and 8
    auto_rts <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      trig <= c[1:0];
      want <= lvl[c][4:0];
      // let the new level take effect before the count is watched
      @(posedge clk);
      for (int i = 0; i < lvl[c] - 1; i++) i_remote.send(8'h30 + i[7:0]);
      check("rts early", 0, rts_n);
      nb = 8'h30 + 8'(lvl[c] - 1);
      fork i_remote.send(nb); join_none
      wait_obs(7, 1'b1);
      t0 = ticks;
      wait_obs(1, 1'b1);
      span("rts high", 0, 2, ticks - t0);
      wait fork;
      for (int i = 0; i < lvl[c]; i++) begin
        check("rx byte", 8'h30 + i, rbuf);
        pulse(1);
        if (i == lvl[c] - 1) begin
          t0 = ticks;
          wait_obs(1, 1'b0);
          span("rts low", 0, 2, ticks - t0);
        end
        repeat (8) @(posedge clk);
      end
    end
    // top threshold, then one character too many
    trig <= 2'h3;
    for (int i = 0; i < 15; i++) i_remote.send(8'h40 + i[7:0]);
    check("rts before 16th", 0, rts_n);
    fork i_remote.send(8'h4f); join_none
    wait_obs(8, 1'b0);
    // measured from the start edge: rts drops at the start-bit midpoint, about 9 ticks in
    t0 = ticks;
    wait_obs(1, 1'b1);
    span("rts at 16th", 0, 18, ticks - t0);
    wait fork;
    i_remote.send(8'h50);
    check("overrun", 1, ls_irq);
    pulse(2);
    repeat (8) @(posedge clk);
    check("overrun clear", 0, ls_irq);
    check("head byte", 8'h40, rbuf);
    pulse(1);
    t0 = ticks;
    wait_obs(1, 1'b0);
    span("rts on read", 0, 2, ticks - t0);
    // automatic clear-to-send holds, starts and halts the sender
    auto_cts <= 1'b1;
    cts_n <= 1'b1;
    wdata <= 8'h3c;
    pulse(0);
    repeat (160) @(posedge clk);
    check("held by cts", 1, tx);
    cts_n <= 1'b0;
    t0 = ticks;
    wait_obs(0, 1'b0);
    span("start on cts", 0, 24, ticks - t0);
    wdata <= 8'h71;
    pulse(0);
    cts_n <= 1'b1; // raised well before the stop-bit midpoint
    repeat (1500) @(posedge clk);
    check("halt count", 3, got_cnt);
    check("first char", 8'h3c, got_byte);
    cts_n <= 1'b0;
    repeat (1500) @(posedge clk);
    check("resume count", 4, got_cnt);
    check("second char", 8'h71, got_byte);
    summarize();
  end
endmodule
`default_nettype wire
